/* File: hdl/uart_data_port.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - Data read returns received byte, pin per mode.
// - Received byte valid only while data ready.
// - No FIFO: new byte overwrites, flags overrun.
// - FIFO mode: read pops oldest receive entry.
// - Full receive FIFO: drop new, flag overrun.
// - Data write queues byte for serial output.
// - No FIFO: write clears empty, rewrite overwrites.
// - FIFO mode: accept depth writes, drop extras.
// - Divisor access: low byte is divisor low.
// - Divisor low reachable only with access bit.
// - Baud equals clock over sixteen times divisor.
module uart_data_port #(
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [31:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Serial and infrared lines
  input wire logic ser_in,
  output logic ser_out,
  input wire logic ir_in,
  output logic ir_out_n,
  // Interrupt
  output logic irq
);
  import uart_port_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CAP_FIFO = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CAP_SINGLE = (AW + 1)'(1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] div_low_q, div_low_d, div_high_q, div_high_d;
  logic [7:0] lctl_q, lctl_d;
  logic fifo_en_q, fifo_en_d;
  logic overrun_q, overrun_d;
  logic [2:0] istat_q, istat_d, imask_q, imask_d;
  logic [15:0] baud_cnt_q, baud_cnt_d;
  logic [2:0] sync_q;
  logic line_q, line_d;
  line_state_e rx_st_q, rx_st_d, tx_st_q, tx_st_d;
  logic [3:0] rx_smp_q, rx_smp_d, tx_smp_q, tx_smp_d;
  logic [2:0] rx_bit_q, rx_bit_d, tx_bit_q, tx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
  logic ser_out_q, ser_out_d, ir_out_n_q, ir_out_n_d;
  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [AW-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [AW:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;

  // Combinational helpers.
  logic req, div_access, ir_mode, tick, rx_done, tx_load, out_bit;
  logic data_rd, data_wr, rx_pop, rx_room, tx_room, fifo_clear;
  logic rx_we, tx_we;
  logic [AW-1:0] rx_waddr, tx_waddr;
  logic [AW:0] cap;
  logic [15:0] divisor;
  logic [7:0] lstat;

  assign req = wb_cyc & wb_stb & ~ack_q;
  assign div_access = lctl_q[LCTL_DIV_ACCESS];
  assign ir_mode = lctl_q[LCTL_IR_MODE];
  assign divisor = {div_high_q, div_low_q};
  assign cap = fifo_en_q ? CAP_FIFO : CAP_SINGLE;
  assign data_rd = req & ~wb_we & (wb_adr == ADDR_DATA) & ~div_access;
  assign data_wr = req & wb_we & wb_sel[0] & (wb_adr == ADDR_DATA) & ~div_access;
  assign rx_pop = data_rd & (rx_cnt_q != '0);
  assign fifo_clear = req & wb_we & wb_sel[0] & (wb_adr == ADDR_FIFO_CTRL) &
                      (wb_dat_w[FCTL_RX_CLEAR] | wb_dat_w[FCTL_TX_CLEAR] |
                       (wb_dat_w[FCTL_FIFO_EN] != fifo_en_q));
  assign lstat = {1'b0, tx_st_q == ST_IDLE && tx_cnt_q == '0, tx_cnt_q == '0,
                  3'b000, overrun_q, rx_cnt_q != '0};

  // ----------------------------------------------------------------
  // Baud tick: one pulse per sixteenth of a bit
  // ----------------------------------------------------------------
  always_comb begin
    tick = 1'b0;
    baud_cnt_d = baud_cnt_q;
    if (divisor == COUNT_RESET) begin
      baud_cnt_d = COUNT_RESET;
    end else if (baud_cnt_q >= divisor - 16'h0001) begin
      tick = 1'b1;
      baud_cnt_d = COUNT_RESET;
    end else begin
      baud_cnt_d = baud_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave and control registers
  // ----------------------------------------------------------------
  always_comb begin
    ack_d = req;
    rdat_d = rdat_q;
    div_low_d = div_low_q;
    div_high_d = div_high_q;
    lctl_d = lctl_q;
    fifo_en_d = fifo_en_q;
    overrun_d = overrun_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (req && !wb_we) begin
      rdat_d = 32'h0000_0000;
      case (wb_adr)
        // received byte read
        // An empty store reads as zero, since its entries may never have been written.
        ADDR_DATA: rdat_d[7:0] = div_access ? div_low_q :
                                 (rx_cnt_q != '0) ? rx_mem[rx_rp_q] : BYTE_RESET;
        ADDR_DIV_HIGH: rdat_d[7:0] = div_high_q;
        ADDR_FIFO_CTRL: rdat_d[FCTL_FIFO_EN] = fifo_en_q;
        ADDR_LINE_CTRL: rdat_d[7:0] = lctl_q;
        ADDR_LINE_STAT: rdat_d[7:0] = lstat;
        ADDR_INT_STAT: rdat_d[2:0] = istat_q;
        ADDR_INT_MASK: rdat_d[2:0] = imask_q;
        default: rdat_d = 32'h0000_0000;
      endcase
      // Reading the status consumes the overrun indication.
      if (wb_adr == ADDR_LINE_STAT) begin
        overrun_d = 1'b0;
      end
    end
    if (req && wb_we && wb_sel[0]) begin
      case (wb_adr)
        ADDR_DATA: div_low_d = div_access ? wb_dat_w[7:0] : div_low_q;
        ADDR_DIV_HIGH: div_high_d = wb_dat_w[7:0];
        ADDR_FIFO_CTRL: fifo_en_d = wb_dat_w[FCTL_FIFO_EN];
        ADDR_LINE_CTRL: lctl_d = wb_dat_w[7:0];
        ADDR_INT_STAT: istat_d = istat_q & ~wb_dat_w[2:0];
        ADDR_INT_MASK: imask_d = wb_dat_w[2:0];
        default: ;
      endcase
    end
    // Events are applied after the clear so that a same-cycle event survives.
    if (rx_done && !rx_room) begin
      overrun_d = 1'b1;
      istat_d[INT_OVERRUN] = 1'b1;
    end
    if (rx_done) begin
      istat_d[INT_RX_DATA] = 1'b1;
    end
    if (tx_load && tx_cnt_q == CAP_SINGLE && !data_wr) begin
      istat_d[INT_TX_EMPTY] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive line: pin synchroniser and frame sampler
  // ----------------------------------------------------------------
  always_comb begin
    line_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : line_q;
    rx_st_d = rx_st_q;
    rx_smp_d = rx_smp_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_done = 1'b0;
    if (tick) begin
      rx_smp_d = rx_smp_q + 4'h1;
      case (rx_st_q)
        ST_IDLE: begin
          rx_smp_d = 4'h0;
          if (!line_q) begin
            rx_st_d = ST_START;
          end
        end
        ST_START: begin
          if (rx_smp_q == SAMPLE_MID) begin
            rx_smp_d = 4'h0;
            rx_bit_d = 3'h0;
            // A start bit that is gone by mid-bit was a glitch.
            rx_st_d = line_q ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_smp_q == SAMPLE_LAST) begin
            rx_sh_d = {line_q, rx_sh_q[7:1]};
            rx_bit_d = rx_bit_q + 3'h1;
            if (rx_bit_q == BIT_LAST) begin
              rx_st_d = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (rx_smp_q == SAMPLE_LAST) begin
            // A frame with a low stop bit is dropped.
            rx_done = line_q;
            rx_st_d = ST_IDLE;
          end
        end
        default: rx_st_d = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive store
  // ----------------------------------------------------------------
  always_comb begin
    rx_wp_d = rx_wp_q;
    rx_rp_d = rx_rp_q;
    rx_cnt_d = rx_cnt_q;
    rx_we = 1'b0;
    rx_waddr = rx_wp_q;
    rx_room = (rx_cnt_q < cap) || rx_pop;
    if (rx_pop) begin
      rx_rp_d = rx_rp_q + 1'b1;
      rx_cnt_d = rx_cnt_q - 1'b1;
    end
    if (rx_done && rx_room) begin
      rx_we = 1'b1;
      rx_wp_d = rx_wp_q + 1'b1;
      rx_cnt_d = rx_cnt_d + 1'b1;
    end else if (rx_done && !fifo_en_q) begin
      rx_we = 1'b1;
      rx_waddr = rx_rp_q;
    end
    // full FIFO drops new byte, handled by leaving rx_we low.
    if (fifo_clear) begin
      rx_wp_d = '0;
      rx_rp_d = '0;
      rx_cnt_d = '0;
      rx_we = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit store
  // ----------------------------------------------------------------
  always_comb begin
    tx_wp_d = tx_wp_q;
    tx_rp_d = tx_rp_q;
    tx_cnt_d = tx_cnt_q;
    tx_we = 1'b0;
    tx_waddr = tx_wp_q;
    tx_load = (tx_st_q == ST_IDLE) && (tx_cnt_q != '0);
    tx_room = (tx_cnt_q < cap) || tx_load;
    if (tx_load) begin
      tx_rp_d = tx_rp_q + 1'b1;
      tx_cnt_d = tx_cnt_q - 1'b1;
    end
    if (data_wr && tx_room) begin
      tx_we = 1'b1;
      tx_wp_d = tx_wp_q + 1'b1;
      tx_cnt_d = tx_cnt_d + 1'b1;
    end else if (data_wr && !fifo_en_q) begin
      tx_we = 1'b1;
      tx_waddr = tx_rp_q;
    end
    // full FIFO drops write, handled by leaving tx_we low.
    if (fifo_clear) begin
      tx_wp_d = '0;
      tx_rp_d = '0;
      tx_cnt_d = '0;
      tx_we = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit line
  // ----------------------------------------------------------------
  always_comb begin
    tx_st_d = tx_st_q;
    tx_smp_d = tx_smp_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    if (tx_st_q == ST_IDLE) begin
      tx_smp_d = 4'h0;
      if (tx_load) begin
        tx_sh_d = tx_mem[tx_rp_q];
        tx_bit_d = 3'h0;
        tx_st_d = ST_START;
      end
    end else if (tick) begin
      tx_smp_d = tx_smp_q + 4'h1;
      if (tx_smp_q == SAMPLE_LAST) begin
        case (tx_st_q)
          ST_START: tx_st_d = ST_DATA;
          ST_DATA: begin
            tx_sh_d = {1'b1, tx_sh_q[7:1]};
            tx_bit_d = tx_bit_q + 3'h1;
            if (tx_bit_q == BIT_LAST) begin
              tx_st_d = ST_STOP;
            end
          end
          ST_STOP: tx_st_d = ST_IDLE;
          default: tx_st_d = ST_IDLE;
        endcase
      end
    end
    case (tx_st_q)
      ST_START: out_bit = 1'b0;
      ST_DATA: out_bit = tx_sh_q[0];
      default: out_bit = 1'b1;
    endcase
    // Infrared sends a short low pulse for each zero bit.
    ser_out_d = ir_mode ? 1'b1 : out_bit;
    ir_out_n_d = ~(ir_mode && !out_bit && tx_smp_q < IR_PULSE);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      div_low_q <= BYTE_RESET;
      div_high_q <= BYTE_RESET;
      lctl_q <= BYTE_RESET;
      fifo_en_q <= 1'b0;
      overrun_q <= 1'b0;
      istat_q <= INT_RESET;
      imask_q <= INT_RESET;
      baud_cnt_q <= COUNT_RESET;
      sync_q <= 3'b111;
      line_q <= 1'b1;
      rx_st_q <= ST_IDLE;
      rx_smp_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= BYTE_RESET;
      tx_st_q <= ST_IDLE;
      tx_smp_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= BYTE_RESET;
      ser_out_q <= 1'b1;
      ir_out_n_q <= 1'b1;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else if (ce) begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      div_low_q <= div_low_d;
      div_high_q <= div_high_d;
      lctl_q <= lctl_d;
      fifo_en_q <= fifo_en_d;
      overrun_q <= overrun_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      baud_cnt_q <= baud_cnt_d;
      sync_q <= {sync_q[1:0], ir_mode ? ~ir_in : ser_in};
      line_q <= line_d;
      rx_st_q <= rx_st_d;
      rx_smp_q <= rx_smp_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      tx_st_q <= tx_st_d;
      tx_smp_q <= tx_smp_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      ser_out_q <= ser_out_d;
      ir_out_n_q <= ir_out_n_d;
      rx_wp_q <= rx_wp_d;
      rx_rp_q <= rx_rp_d;
      rx_cnt_q <= rx_cnt_d;
      tx_wp_q <= tx_wp_d;
      tx_rp_q <= tx_rp_d;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // Storage arrays carry no reset; contents are only read once written.
  always_ff @(posedge clk) begin
    if (ce && rx_we) begin
      rx_mem[rx_waddr] <= rx_sh_d;
    end
    if (ce && tx_we) begin
      tx_mem[tx_waddr] <= wb_dat_w[7:0];
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = rdat_q;
  assign ser_out = ser_out_q;
  assign ir_out_n = ir_out_n_q;
  assign irq = |(istat_q & imask_q);

endmodule : uart_data_port

/* File: hdl/uart_port_pkg.sv */
package uart_port_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_DATA = 32'h5000_1000;
  localparam logic [31:0] ADDR_DIV_HIGH = 32'h5000_1004;
  localparam logic [31:0] ADDR_FIFO_CTRL = 32'h5000_1008;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'h5000_100C;
  localparam logic [31:0] ADDR_LINE_STAT = 32'h5000_1014;
  localparam logic [31:0] ADDR_INT_STAT = 32'h5000_1020;
  localparam logic [31:0] ADDR_INT_MASK = 32'h5000_1024;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LCTL_DIV_ACCESS = 7;
  localparam int LCTL_IR_MODE = 6;
  localparam int FCTL_FIFO_EN = 0;
  localparam int FCTL_RX_CLEAR = 1;
  localparam int FCTL_TX_CLEAR = 2;
  localparam int LSTAT_DATA_READY = 0;
  localparam int LSTAT_OVERRUN = 1;
  localparam int LSTAT_THR_EMPTY = 5;
  localparam int LSTAT_TX_IDLE = 6;
  localparam int INT_RX_DATA = 0;
  localparam int INT_OVERRUN = 1;
  localparam int INT_TX_EMPTY = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] INT_RESET = 3'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] SAMPLE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } line_state_e;

endpackage : uart_port_pkg

/* File: testbench/uart_data_port_sva.sv */
`timescale 1ns/1ps
module uart_data_port_chk (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [31:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack,
  // Lines and interrupt
  input wire logic ser_out,
  input wire logic ir_out_n,
  input wire logic irq
);
  import uart_port_pkg::*;
  logic req;
  logic ir_q;
  logic ir_d;
  assign req = ce && wb_cyc && wb_stb && !wb_ack;
  // The infrared mode bit is shadowed from bus writes, since it is not visible at the ports.
  always_comb begin
    ir_d = ir_q;
    if (req && wb_we && wb_sel[0] && wb_adr == ADDR_LINE_CTRL) begin
      ir_d = wb_dat_w[LCTL_IR_MODE];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_q <= 1'b0;
    end else begin
      ir_q <= ir_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_after_req: assert property (req |=> wb_ack)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack && ce |=> !wb_ack)
    else $error("ack longer than one cycle");
  a_no_ack_idle: assert property (!(wb_cyc && wb_stb) |=> !wb_ack)
    else $error("ack without request");
  a_upper_byte_zero: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_rdata_holds: assert property (!(req && !wb_we) |=> $stable(wb_dat_r))
    else $error("read data changed without a read");
  a_start_bit_len: assert property ($fell(ser_out) |-> !ser_out [*8])
    else $error("serial low run too short");
  a_ser_high_ir: assert property (ir_q && $past(ir_q) |-> ser_out)
    else $error("serial output active in infrared mode");
  a_ir_high_uart: assert property (!ir_q && !$past(ir_q) |-> ir_out_n)
    else $error("infrared output active in serial mode");
  c_read_ack: cover property (wb_ack && !wb_we);
  c_tx_start: cover property ($fell(ser_out));
  c_irq_rise: cover property ($rose(irq));
endmodule : uart_data_port_chk

bind uart_data_port uart_data_port_chk chk_u (
  .clk(clk), .rst(rst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
  .wb_ack(wb_ack), .ser_out(ser_out), .ir_out_n(ir_out_n), .irq(irq)
);

/* File: testbench/uart_remote.sv */
`timescale 1ns/1ps
module uart_remote #(
  parameter int BIT_CYC = 32
) (
  // Clock
  input wire logic clk,
  // Serial lines, idle high
  output logic line_tx,
  input wire logic line_rx
);
  initial begin
    line_tx = 1'b1;
  end

  // Frames go out LSB first between a low start and a high stop bit.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_tx <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : send

  // Bit 9 flags a missing start bit, bit 8 is the stop bit.
  task automatic recv(output logic [9:0] v);
    int n;
    n = 0;
    v = 10'h000;
    while (line_rx !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    v[9] = (n >= 4000);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      v[i] = line_rx;
    end
  endtask : recv
endmodule : uart_remote

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import uart_port_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk, rst, ce, wb_cyc, wb_stb, wb_we, wb_ack;
  logic ser_out, ir_out_n, irq, line;
  logic [3:0] wb_sel;
  logic [3:0] sel_v;
  logic [31:0] wb_adr, wb_dat_w, wb_dat_r;
  int errors;
  int comparisons;

  uart_data_port #(.DEPTH(16)) dut_u (.clk(clk), .rst(rst), .ce(ce), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .ser_in(line), .ser_out(ser_out),
    .ir_in(~line), .ir_out_n(ir_out_n), .irq(irq));
  // Divisor 2 gives 32 clock cycles per bit.
  uart_remote #(.BIT_CYC(32)) remote_u (.clk(clk), .line_tx(line), .line_rx(ser_out));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dw,
                      output logic [31:0] dr);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dw;
    wb_sel <= sel_v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    dr = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      errors++;
      finish_test();
    end
  endtask : xfer

  task automatic wr(input logic [31:0] adr, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, adr, d, x);
  endtask : wr

  task automatic rdc(input logic [31:0] adr, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, adr, 32'h0000_0000, x);
    check(x & m, e);
  endtask : rdc

  task automatic tx_chk(input logic [7:0] e);
    logic [9:0] v;
    remote_u.recv(v);
    if (v[9]) begin
      errors++;
      finish_test();
    end
    check(32'(v[8:0]), {23'h00_0000, 1'b1, e});
  endtask : tx_chk

  task automatic t_divisor;
    rdc(ADDR_DATA, ALL, 32'h0000_0000);
    wr(ADDR_LINE_CTRL, 32'h0000_0080);
    wr(ADDR_DATA, 32'hABCD_1202);
    wr(ADDR_DIV_HIGH, 32'h0000_0000);
    rdc(ADDR_DATA, ALL, 32'h0000_0002);
    // A write without the low byte lane must leave the divisor alone.
    sel_v = 4'hE;
    wr(ADDR_DATA, 32'h0000_0077);
    sel_v = 4'hF;
    rdc(ADDR_DATA, ALL, 32'h0000_0002);
    wr(ADDR_LINE_CTRL, 32'h0000_0000);
    rdc(ADDR_DATA, ALL, 32'h0000_0000);
    rdc(ADDR_LINE_STAT, 32'h0000_0060, 32'h0000_0060);
    rdc(32'h5000_1030, ALL, 32'h0000_0000);
  endtask : t_divisor

  task automatic t_tx_plain;
    rdc(ADDR_LINE_STAT, 32'h0000_0020, 32'h0000_0020);
    wr(ADDR_DATA, 32'h0000_005A);
    fork
      tx_chk(8'h5A);
      begin
        repeat (8) @(posedge clk);
        wr(ADDR_DATA, 32'h0000_0011);
        rdc(ADDR_LINE_STAT, 32'h0000_0020, 32'h0000_0000);
        wr(ADDR_DATA, 32'h0000_0033);
      end
    join
    tx_chk(8'h33);
  endtask : t_tx_plain

  // A low clock enable must hold the line mid-frame, so the bit would otherwise move on.
  task automatic t_freeze;
    int n;
    wr(ADDR_DATA, 32'h0000_0055);
    n = 0;
    while (ser_out !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    check(32'(ser_out), 32'h0000_0000);
    ce <= 1'b1;
    repeat (400) @(posedge clk);
    rdc(ADDR_LINE_STAT, 32'h0000_0060, 32'h0000_0060);
  endtask : t_freeze

  // Infrared transmit: one low pulse per zero bit, start bit included.
  task automatic t_ir_tx;
    int falls;
    int lows;
    logic prev;
    wr(ADDR_LINE_CTRL, 32'h0000_0040);
    wr(ADDR_DATA, 32'h0000_00A5);
    falls = 0;
    lows = 0;
    prev = 1'b1;
    repeat (400) begin
      @(posedge clk);
      if (prev && !ir_out_n) falls++;
      if (!ser_out) lows++;
      prev = ir_out_n;
    end
    check(32'(falls), 32'h0000_0005);
    check(32'(lows), 32'h0000_0000);
    wr(ADDR_LINE_CTRL, 32'h0000_0000);
  endtask : t_ir_tx

  task automatic t_rx_plain;
    wr(ADDR_INT_MASK, 32'h0000_0001);
    remote_u.send(8'hA5);
    check(32'(irq), 32'h0000_0001);
    rdc(ADDR_LINE_STAT, 32'h0000_0003, 32'h0000_0001);
    rdc(ADDR_DATA, ALL, 32'h0000_00A5);
    rdc(ADDR_LINE_STAT, 32'h0000_0001, 32'h0000_0000);
    wr(ADDR_INT_MASK, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    wr(ADDR_INT_MASK, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(ADDR_INT_STAT, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    remote_u.send(8'h3C);
    remote_u.send(8'hC3);
    rdc(ADDR_LINE_STAT, 32'h0000_0003, 32'h0000_0003);
    rdc(ADDR_DATA, ALL, 32'h0000_00C3);
    wr(ADDR_LINE_CTRL, 32'h0000_0040);
    remote_u.send(8'h96);
    rdc(ADDR_DATA, ALL, 32'h0000_0096);
    wr(ADDR_LINE_CTRL, 32'h0000_0000);
  endtask : t_rx_plain

  task automatic t_fifo;
    wr(ADDR_FIFO_CTRL, 32'h0000_0001);
    wr(ADDR_INT_STAT, 32'h0000_0006);
    for (int i = 0; i < 17; i++) remote_u.send(8'h40 + 8'(i));
    rdc(ADDR_LINE_STAT, 32'h0000_0002, 32'h0000_0002);
    rdc(ADDR_INT_STAT, 32'h0000_0002, 32'h0000_0002);
    for (int i = 0; i < 16; i++) rdc(ADDR_DATA, ALL, 32'h0000_0040 + 32'(i));
    rdc(ADDR_LINE_STAT, 32'h0000_0001, 32'h0000_0000);
    fork
      for (int i = 0; i < 18; i++) wr(ADDR_DATA, 32'h0000_0080 + 32'(i));
      for (int j = 0; j < 17; j++) tx_chk(8'h80 + 8'(j));
    join
    repeat (64) @(posedge clk);
    rdc(ADDR_LINE_STAT, 32'h0000_0060, 32'h0000_0060);
    rdc(ADDR_INT_STAT, 32'h0000_0004, 32'h0000_0004);
  endtask : t_fifo

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    ce = 1'b1;
    sel_v = 4'hF;
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat_w} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_divisor();
    t_tx_plain();
    t_freeze();
    t_rx_plain();
    t_ir_tx();
    t_fifo();
    finish_test();
  end
endmodule : testbench
